// file: itv_pkg.sv
/*
  Shared constants for the trap and interrupt vector unit: register
  offsets, field positions, reset values, trap numbers and encodings.
  Assumes a single core clock and a plain register port.
*/
`default_nettype none
package itv_pkg;
  // Interrupt nodes cover trap numbers 10h..5Fh
  localparam int unsigned NODE_CNT  = 80;
  localparam logic [6:0]  NODE_BASE = 7'h10;
  localparam logic [6:0]  NODE_LAST = 7'h5f;

  // Register offsets on the plain register port
  localparam logic [3:0] ADDR_VECTOR_SEGMENT_REG    = 4'h0;
  localparam logic [3:0] ADDR_CPU_CONFIG_REG_ONE   = 4'h1;
  localparam logic [3:0] ADDR_TRAPFLAG  = 4'h2;
  localparam logic [3:0] ADDR_NODESEL   = 4'h3;
  localparam logic [3:0] ADDR_NODECTRL  = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h5;

  // Spacing field: bytes between vectors = 4 << code
  localparam int unsigned SPC_LSB        = 0;
  localparam logic [1:0]  SPC_RESET      = 2'h0;
  localparam int unsigned SPC_BASE_SHIFT = 2;
  localparam logic [7:0]  SEG_RESET      = 8'h00;

  // Node control fields
  localparam int unsigned NCTRL_REQ      = 7;
  localparam int unsigned NCTRL_EN       = 6;
  localparam int unsigned NCTRL_PRIO_LSB = 0;

  // Trap flag register bits
  localparam int unsigned TF_NMI       = 15;
  localparam int unsigned TF_STK_OVER  = 14;
  localparam int unsigned TF_STK_UNDER = 13;
  localparam int unsigned TF_SBRK      = 12;
  localparam int unsigned TF_UNDEF_OPC = 7;
  localparam int unsigned TF_PROG_ERR  = 3;
  localparam int unsigned TF_PROT      = 2;
  localparam int unsigned TF_ILL_WORD  = 1;

  // Hardware trap numbers
  localparam logic [6:0] TRAP_RESET     = 7'h00;
  localparam logic [6:0] TRAP_NMI       = 7'h02;
  localparam logic [6:0] TRAP_STK_OVER  = 7'h04;
  localparam logic [6:0] TRAP_STK_UNDER = 7'h06;
  localparam logic [6:0] TRAP_SBRK      = 7'h08;
  localparam logic [6:0] TRAP_CLASS_B   = 7'h0a;

  // Peripheral node trap numbers
  localparam logic [6:0] TRAP_AS0_TX  = 7'h2a;
  localparam logic [6:0] TRAP_AS0_TB  = 7'h47;
  localparam logic [6:0] TRAP_AS0_RX  = 7'h2b;
  localparam logic [6:0] TRAP_AS0_ER  = 7'h2c;
  localparam logic [6:0] TRAP_AS0_AB  = 7'h5f;
  localparam logic [6:0] TRAP_AS1_TX  = 7'h48;
  localparam logic [6:0] TRAP_AS1_TB  = 7'h5e;
  localparam logic [6:0] TRAP_AS1_RX  = 7'h49;
  localparam logic [6:0] TRAP_AS1_ER  = 7'h4a;
  localparam logic [6:0] TRAP_AS1_AB  = 7'h42;
  localparam logic [6:0] TRAP_XFER_END = 7'h4c;
  localparam logic [6:0] TRAP_RTC     = 7'h5d;
  localparam logic [6:0] TRAP_OSC_WD  = 7'h43;
  localparam logic [6:0] TRAP_CAP_REL = 7'h27;
  localparam logic [6:0] TRAP_SS0_TX  = 7'h2d;
  localparam logic [6:0] TRAP_SS0_RX  = 7'h2e;
  localparam logic [6:0] TRAP_SS0_ER  = 7'h2f;
  localparam logic [6:0] TRAP_SS1_TX  = 7'h51;
  localparam logic [6:0] TRAP_SS1_RX  = 7'h52;
  localparam logic [6:0] TRAP_SS1_ER  = 7'h53;

  // Expected offsets at default spacing
  localparam logic [15:0] OFF_AS0_TX = 16'h00a8;
  localparam logic [15:0] OFF_RTC    = 16'h0174;

  // Trap class in progress, ordered by trap priority
  typedef enum logic [1:0] {CLS_NONE, CLS_B, CLS_A, CLS_RST} itv_cls_t;
  typedef enum logic [1:0] {KIND_IRQ, KIND_TRAP, KIND_SWT} itv_kind_t;

  // Nodes with no peripheral behind them
  function automatic logic is_unassigned(input logic [6:0] num);
    return num inside {[7'h10:7'h17], [7'h1e:7'h21], 7'h28, 7'h29,
                       [7'h3f:7'h41], 7'h4b, [7'h4d:7'h50],
                       [7'h54:7'h5c]};
  endfunction
endpackage
`default_nettype wire

// file: itv_vec_calc.sv
/*
  Vector address former: segment in the upper byte, trap number
  times the spacing in the lower sixteen bits. Purely combinational;
  the caller registers the result.
*/
`default_nettype none
module itv_vec_calc (
  // Trap number and settings
  input  wire logic [6:0]  i_num,
  input  wire logic [7:0]  i_seg,
  input  wire logic [1:0]  i_spc,
  // Formed vector address
  output logic      [23:0] o_addr
);
  import itv_pkg::*;

  logic [15:0] offset;

  // Offset is the trap number shifted left by two plus the spacing code
  always_comb begin
    offset = 16'({9'h000, i_num} << (SPC_BASE_SHIFT + 32'(i_spc)));
    o_addr = {i_seg, offset};
  end
endmodule
`default_nettype wire

// file: itv_node_arb.sv
/*
  Interrupt node arbiter: finds the enabled pending node with the
  highest priority level; on a tie the lowest node index wins.
*/
`default_nettype none
module itv_node_arb (
  // Node state
  input  wire logic [itv_pkg::NODE_CNT-1:0]      i_req,
  input  wire logic [itv_pkg::NODE_CNT-1:0]      i_en,
  input  wire logic [itv_pkg::NODE_CNT-1:0][3:0] i_prio,
  // Winner
  output logic                                   o_found,
  output logic      [6:0]                        o_idx,
  output logic      [3:0]                        o_prio
);
  import itv_pkg::*;

  // Linear scan, strictly higher level replaces the winner
  always_comb begin
    o_found = 1'b0;
    o_idx   = 7'h00;
    o_prio  = 4'h0;
    for (int k = 0; k < NODE_CNT; k++) begin
      if (i_req[k] && i_en[k] && (!o_found || i_prio[k] > o_prio)) begin
        o_found = 1'b1;
        o_idx   = 7'(k);
        o_prio  = i_prio[k];
      end
    end
  end
endmodule
`default_nettype wire

// file: itv_trap_vec.sv
/*
  Trap and interrupt vector unit: node control, hardware trap flags
  and arbitration, and the vector offered to the core.
  Assumes the core acks an offer with a one-cycle pulse and reports
  its current priority level; trap inputs are same-clock pulses
  except the nonmaskable pin, which is synchronised here.
*/
// Decided for this implementation: the register offsets and the plain strobed port.
// Notes on behaviour
// RL1: Vector is segment plus number times spacing
// RL2: Spacing field defaults to four bytes
// RL3: Async serial nodes use fixed trap numbers
// RL4: Other peripheral nodes use fixed trap numbers
// RL5: Unassigned nodes still own vector slots
// RL6: Hardware traps vector at once, nonmaskable
// RL7: Each hardware trap sets its own flag
// RL8: Traps preempt unless higher trap runs; code also holds a trap while one of its own class runs
// RL9: No interrupts during a hardware trap service
// RL10: Reset sources vector to zero, no flag
// RL11: Class A traps own flag and vector
// RL12: Class B traps share one vector
// RL13: Software trap takes any number, keeps priority
// RL14: Node has request, enable, sixteen-level priority
// RL15: Only higher priority interrupts a service
// RL16: Software may set an unassigned request
// RL17: Flags sticky; reset beats A beats B
// RL18: Settings sampled when each vector forms
`default_nettype none
module itv_trap_vec (
  // Clock, reset, enable
  input  wire logic                         i_core_clk,
  input  wire logic                         i_rst_n,
  input  wire logic                         i_ce,
  // Register port
  input  wire logic [3:0]                   i_reg_addr,
  input  wire logic [15:0]                  i_reg_wdata,
  input  wire logic                         i_reg_wr,
  input  wire logic                         i_reg_rd,
  output logic      [15:0]                  o_reg_rdata,
  // Peripheral node requests, bit k is trap number 10h+k
  input  wire logic [itv_pkg::NODE_CNT-1:0] i_node_req,
  // Reset sources
  input  wire logic                         i_hw_reset,
  input  wire logic                         i_sw_reset,
  input  wire logic                         i_wdt_ovf,
  // Class A sources (pin is asynchronous)
  input  wire logic                         i_nmi_pin,
  input  wire logic                         i_stk_over,
  input  wire logic                         i_stk_under,
  input  wire logic                         i_soft_break,
  // Class B sources
  input  wire logic                         i_undef_opc,
  input  wire logic                         i_prog_err,
  input  wire logic                         i_prot_fault,
  input  wire logic                         i_ill_word,
  // Core side
  input  wire logic                         i_swtrap_req,
  input  wire logic [6:0]                   i_swtrap_num,
  input  wire logic [3:0]                   i_cpu_prio,
  input  wire logic                         i_vec_ack,
  input  wire logic                         i_trap_ret,
  output logic                              o_vec_valid,
  output logic      [23:0]                  o_vec_addr,
  output logic      [6:0]                   o_trap_num,
  output logic      [3:0]                   o_vec_prio,
  output logic                              o_vec_is_trap,
  output logic                              o_vec_is_swtrap,
  output logic                              o_trap_active
);
  import itv_pkg::*;

  typedef struct packed {
    logic [7:0]                seg;
    logic [1:0]                spc;
    logic [15:0]               tflag;
    logic [6:0]                nsel;
    logic [NODE_CNT-1:0]       nreq;
    logic [NODE_CNT-1:0]       nen;
    logic [NODE_CNT-1:0][3:0]  nprio;
    logic                      rst_idle;
    logic [3:0]                a_pend;
    logic                      b_pend;
    logic                      sw_pend;
    logic [6:0]                sw_num;
    itv_cls_t                  active;
    logic [1:0]                nmi_sync;
    logic                      nmi_last;
    logic                      vvalid;
    logic [23:0]               vaddr;
    logic [6:0]                vnum;
    itv_kind_t                 vkind;
    itv_cls_t                  vcls;
    logic [1:0]                vsrc;
    logic [3:0]                vprio;
    logic [15:0]               rdata;
  } itv_state_t;

  itv_state_t s_ff;
  itv_state_t nxt_s;

  logic        arb_found;
  logic [6:0]  arb_idx;
  logic [3:0]  arb_prio;
  logic [23:0] cand_addr;
  logic        cand_ok;
  logic [6:0]  cand_num;
  itv_kind_t   cand_kind;
  itv_cls_t    cand_cls;
  logic [1:0]  cand_src;
  logic [3:0]  cand_prio;
  logic [3:0]  ev_a;
  logic [3:0]  ev_b;
  logic        ack;

  // Node index from a trap number
  function automatic logic [6:0] node_idx(input logic [6:0] num);
    return 7'(num - NODE_BASE);
  endfunction

  // Trap number of a class A source, 3 is the highest
  function automatic logic [6:0] a_trap(input logic [1:0] src);
    logic [6:0] r;
    r = TRAP_SBRK;
    unique case (src)
      2'h3: r = TRAP_NMI;
      2'h2: r = TRAP_STK_OVER;
      2'h1: r = TRAP_STK_UNDER;
      2'h0: r = TRAP_SBRK;
    endcase
    return r;
  endfunction

  itv_node_arb u_arb (
    .i_req   (s_ff.nreq),
    .i_en    (s_ff.nen),
    .i_prio  (s_ff.nprio),
    .o_found (arb_found),
    .o_idx   (arb_idx),
    .o_prio  (arb_prio)
  );

  // Segment and spacing are read live as the vector forms
  itv_vec_calc u_calc (
    .i_num  (cand_num),
    .i_seg  (s_ff.seg),  // RL18
    .i_spc  (s_ff.spc),
    .o_addr (cand_addr)
  );

  // Candidate: reset, class A, class B, software trap, interrupt
  always_comb begin
    cand_ok   = 1'b0;
    cand_num  = TRAP_RESET;
    cand_kind = KIND_IRQ;
    cand_cls  = CLS_NONE;
    cand_src  = 2'h0;
    cand_prio = i_cpu_prio;
    if (!s_ff.rst_idle) begin
      cand_ok   = 1'b1;  // RL10
      cand_kind = KIND_TRAP;
      cand_cls  = CLS_RST;
    end else if (|s_ff.a_pend && s_ff.active < CLS_A) begin  // RL8
      cand_ok   = 1'b1;
      cand_kind = KIND_TRAP;
      cand_cls  = CLS_A;
      for (int k = 0; k < 4; k++) begin
        if (s_ff.a_pend[k]) begin
          cand_src = 2'(k);  // RL17
        end
      end
      cand_num  = a_trap(cand_src);  // RL11
    end else if (s_ff.b_pend && s_ff.active == CLS_NONE) begin
      cand_ok   = 1'b1;
      cand_kind = KIND_TRAP;
      cand_cls  = CLS_B;
      cand_num  = TRAP_CLASS_B;  // RL12
    end else if (s_ff.sw_pend) begin
      cand_ok   = 1'b1;
      cand_kind = KIND_SWT;
      cand_num  = s_ff.sw_num;  // RL13
    end else if (arb_found && s_ff.active == CLS_NONE &&  // RL9
                 arb_prio > i_cpu_prio) begin  // RL15
      cand_ok   = 1'b1;
      cand_num  = 7'(arb_idx + NODE_BASE);  // RL3 RL4
      cand_prio = arb_prio;
    end
  end

  // Next state: acks and software clears first, hardware sets last
  always_comb begin
    nxt_s = s_ff;
    ack   = i_vec_ack && s_ff.vvalid;
    nxt_s.nmi_sync = {s_ff.nmi_sync[0], i_nmi_pin};
    nxt_s.nmi_last = s_ff.nmi_sync[1];
    ev_a = {s_ff.nmi_sync[1] & ~s_ff.nmi_last, i_stk_over, i_stk_under,
            i_soft_break};
    ev_b = {i_undef_opc, i_prog_err, i_prot_fault, i_ill_word};
    if (i_trap_ret) begin
      nxt_s.active = CLS_NONE;
    end
    // Acknowledge retires the offered source
    if (ack) begin
      nxt_s.vvalid = 1'b0;
      unique case (s_ff.vkind)
        KIND_IRQ:  nxt_s.nreq[node_idx(s_ff.vnum)] = 1'b0;
        KIND_SWT:  nxt_s.sw_pend = 1'b0;
        KIND_TRAP: begin
          unique case (s_ff.vcls)
            CLS_RST:  nxt_s.rst_idle = 1'b1;
            CLS_A:    nxt_s.a_pend[s_ff.vsrc] = 1'b0;
            CLS_B:    nxt_s.b_pend = 1'b0;
            CLS_NONE: ;
          endcase
          nxt_s.active = (s_ff.vcls == CLS_RST) ? CLS_NONE : s_ff.vcls;
        end
        default: ;
      endcase
    end
    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_VECTOR_SEGMENT_REG:   nxt_s.seg = i_reg_wdata[7:0];
        ADDR_CPU_CONFIG_REG_ONE:  nxt_s.spc = i_reg_wdata[SPC_LSB +: 2];
        ADDR_TRAPFLAG: nxt_s.tflag = s_ff.tflag & ~i_reg_wdata;
        ADDR_NODESEL:  nxt_s.nsel = i_reg_wdata[6:0];
        ADDR_NODECTRL: begin
          if (s_ff.nsel >= NODE_BASE && s_ff.nsel <= NODE_LAST) begin
            nxt_s.nreq[node_idx(s_ff.nsel)] =
              i_reg_wdata[NCTRL_REQ];  // RL16
            nxt_s.nen[node_idx(s_ff.nsel)] = i_reg_wdata[NCTRL_EN];  // RL14
            nxt_s.nprio[node_idx(s_ff.nsel)] =
              i_reg_wdata[NCTRL_PRIO_LSB +: 4];
          end
        end
        default: ;
      endcase
    end
    // Register reads, answered next cycle
    nxt_s.rdata = 16'h0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_VECTOR_SEGMENT_REG:   nxt_s.rdata = {8'h00, s_ff.seg};
        ADDR_CPU_CONFIG_REG_ONE:  nxt_s.rdata = 16'({s_ff.spc} << SPC_LSB);
        ADDR_TRAPFLAG: nxt_s.rdata = s_ff.tflag;
        ADDR_NODESEL:  nxt_s.rdata = {9'h000, s_ff.nsel};
        ADDR_NODECTRL: begin
          if (s_ff.nsel >= NODE_BASE && s_ff.nsel <= NODE_LAST) begin
            nxt_s.rdata[NCTRL_REQ] = s_ff.nreq[node_idx(s_ff.nsel)];
            nxt_s.rdata[NCTRL_EN]  = s_ff.nen[node_idx(s_ff.nsel)];
            nxt_s.rdata[NCTRL_PRIO_LSB +: 4] =
              s_ff.nprio[node_idx(s_ff.nsel)];
          end
        end
        ADDR_STATUS: nxt_s.rdata = {13'h0000, s_ff.vvalid, s_ff.active};
        default: ;
      endcase
    end
    // Peripheral requests reach assigned nodes only
    for (int k = 0; k < NODE_CNT; k++) begin
      if (i_node_req[k] && !is_unassigned(7'(k + NODE_BASE))) begin  // RL5
        nxt_s.nreq[k] = 1'b1;
      end
    end
    if (i_swtrap_req) begin
      nxt_s.sw_pend = 1'b1;
      nxt_s.sw_num  = i_swtrap_num;
    end
    // Trap sources: pending bits and sticky flags, set wins
    if (i_hw_reset || i_sw_reset || i_wdt_ovf) begin
      nxt_s.rst_idle = 1'b0;  // RL10
    end
    nxt_s.a_pend = nxt_s.a_pend | ev_a;  // RL6
    nxt_s.b_pend = nxt_s.b_pend | (|ev_b);
    nxt_s.tflag[TF_NMI]       = nxt_s.tflag[TF_NMI] | ev_a[3];  // RL7
    nxt_s.tflag[TF_STK_OVER]  = nxt_s.tflag[TF_STK_OVER] | ev_a[2];
    nxt_s.tflag[TF_STK_UNDER] = nxt_s.tflag[TF_STK_UNDER] | ev_a[1];
    nxt_s.tflag[TF_SBRK]      = nxt_s.tflag[TF_SBRK] | ev_a[0];
    nxt_s.tflag[TF_UNDEF_OPC] = nxt_s.tflag[TF_UNDEF_OPC] | ev_b[3];
    nxt_s.tflag[TF_PROG_ERR]  = nxt_s.tflag[TF_PROG_ERR] | ev_b[2];
    nxt_s.tflag[TF_PROT]      = nxt_s.tflag[TF_PROT] | ev_b[1];
    nxt_s.tflag[TF_ILL_WORD]  = nxt_s.tflag[TF_ILL_WORD] | ev_b[0];  // RL17
    // Offer, or replace a lower offer with a trap of higher class
    if (cand_ok && !ack && (!s_ff.vvalid || cand_cls > s_ff.vcls)) begin
      nxt_s.vvalid = 1'b1;
      nxt_s.vaddr  = cand_addr;  // RL1
      nxt_s.vnum   = cand_num;
      nxt_s.vkind  = cand_kind;
      nxt_s.vcls   = cand_cls;
      nxt_s.vsrc   = cand_src;
      nxt_s.vprio  = cand_prio;
    end
  end

  // State register; reset state is all zero, reset vector pending
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_ff <= '0;  // RL2
    end else if (i_ce) begin
      s_ff <= nxt_s;
    end
  end

  // Outputs
  assign o_reg_rdata     = s_ff.rdata;
  assign o_vec_valid     = s_ff.vvalid;
  assign o_vec_addr      = s_ff.vaddr;
  assign o_trap_num      = s_ff.vnum;
  assign o_vec_prio      = s_ff.vprio;
  assign o_vec_is_trap   = (s_ff.vkind == KIND_TRAP);
  assign o_vec_is_swtrap = (s_ff.vkind == KIND_SWT);
  assign o_trap_active   = (s_ff.active != CLS_NONE);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_offer;
    $rose(o_vec_valid);
  endsequence

  a_vec_addr_form: assert property (s_offer |-> o_vec_addr == {$past(s_ff.seg), // RL1
    16'({9'h000, o_trap_num} << (SPC_BASE_SHIFT + 32'($past(s_ff.spc))))})
    else $error("vector address not segment plus scaled number");
  a_default_spacing: assert property (s_offer and $past(s_ff.spc) == SPC_RESET // RL2
    |-> o_vec_addr[15:0] == {7'h00, o_trap_num, 2'b00})
    else $error("default spacing is not four bytes");
  a_async_tx_slot: assert property (s_offer and o_trap_num == TRAP_AS0_TX && // RL3
    $past(s_ff.spc) == SPC_RESET |-> o_vec_addr[15:0] == OFF_AS0_TX)
    else $error("async transmit vector misplaced");
  a_rtc_slot: assert property (s_offer and o_trap_num == TRAP_RTC && // RL4
    $past(s_ff.spc) == SPC_RESET |-> o_vec_addr[15:0] == OFF_RTC)
    else $error("clock node vector misplaced");
  a_sw_set_unassigned: assert property (i_ce && i_reg_wr && // RL16
    i_reg_addr == ADDR_NODECTRL && i_reg_wdata[NCTRL_REQ] &&
    is_unassigned(s_ff.nsel) |=> s_ff.nreq[node_idx($past(s_ff.nsel))])
    else $error("software request on free node lost");
  a_stk_over_offer: assert property (i_ce && s_ff.rst_idle && // RL6
    s_ff.a_pend == 4'b0100 && !s_ff.vvalid && s_ff.active == CLS_NONE
    |=> o_vec_valid && o_trap_num == TRAP_STK_OVER)
    else $error("stack overflow trap not offered at once");
  a_flag_set: assert property (i_ce && i_stk_under // RL7
    |=> s_ff.tflag[TF_STK_UNDER])
    else $error("stack underflow flag not set");
  a_flag_sticky: assert property (i_ce && s_ff.tflag[TF_SBRK] && // RL17
    !(i_reg_wr && i_reg_addr == ADDR_TRAPFLAG) |=> s_ff.tflag[TF_SBRK])
    else $error("trap flag dropped without software");
  a_irq_no_trap: assert property (s_offer and !o_vec_is_trap && // RL9
    !o_vec_is_swtrap |-> $past(s_ff.active) == CLS_NONE)
    else $error("interrupt offered during trap service");
  a_irq_higher: assert property (s_offer and !o_vec_is_trap && // RL15
    !o_vec_is_swtrap |-> o_vec_prio > $past(i_cpu_prio))
    else $error("interrupt not above core priority");
  a_class_b_vec: assert property (s_offer and s_ff.vcls == CLS_B // RL12
    |-> o_trap_num == TRAP_CLASS_B)
    else $error("class B trap number wrong");
  a_reset_vec: assert property (s_offer and s_ff.vcls == CLS_RST // RL10
    |-> o_trap_num == TRAP_RESET)
    else $error("reset source not at trap zero");
  a_swtrap_prio: assert property (s_offer and o_vec_is_swtrap // RL13
    |-> o_vec_prio == $past(i_cpu_prio))
    else $error("software trap changed priority");
endmodule
`default_nettype wire

// file: itv_core_model.sv
/*
  Core model: accepts every vector offer after a fixed pause and keeps
  the fields taken. Assumes one clock and an active low reset.
*/
`default_nettype none
module itv_core_model #(
  parameter int ACK_WAIT = 2
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // Offer from the vector unit
  input  wire logic        i_vec_valid,
  input  wire logic [23:0] i_vec_addr,
  input  wire logic [6:0]  i_trap_num,
  input  wire logic [3:0]  i_vec_prio,
  // Acceptance and what was taken
  output logic             o_vec_ack,
  output logic      [23:0] o_seen_addr,
  output logic      [6:0]  o_seen_num,
  output logic      [3:0]  o_seen_prio,
  output logic      [15:0] o_seen_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_ff;
  // Ack after a pause; fields are taken at the edge that sees the ack
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_vec_ack   <= 1'b0;
      o_seen_addr <= '0;
      o_seen_num  <= '0;
      o_seen_prio <= '0;
      o_seen_cnt  <= '0;
      wait_ff     <= '0;
    end else if (o_vec_ack) begin
      o_vec_ack   <= 1'b0;
      o_seen_addr <= i_vec_addr;
      o_seen_num  <= i_trap_num;
      o_seen_prio <= i_vec_prio;
      o_seen_cnt  <= o_seen_cnt + 16'h0001;
      wait_ff     <= '0;
    end else if (i_vec_valid) begin
      if (wait_ff == ACK_WAIT[3:0]) begin
        o_vec_ack <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end else begin
      wait_ff <= '0;
    end
  end
endmodule
`default_nettype wire

// file: test_itv_trap_vec.sv
/*
  Self-checking bench for the trap and interrupt vector unit.
  Assumes the core model acks every offer after a short pause.
*/
`default_nettype none
module test_itv_trap_vec;
  timeunit 1ns;
  timeprecision 1ns;
  import itv_pkg::*;
  logic        clk;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = '0;
  logic [15:0] wdata = '0;
  logic [15:0] rdata;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        swreq = 1'b0;
  logic        tret = 1'b0;
  logic        ack, vld, act, itrap, iswt;
  logic [79:0] nreq = '0;
  logic [10:0] src = '0;
  logic [6:0]  swnum = '0;
  logic [3:0]  cpu_prio = '0;
  logic [6:0]  num, s_num;
  logic [3:0]  vprio, s_prio;
  logic [23:0] vaddr, s_addr;
  logic [15:0] s_cnt;
  int          bad_count, total_checks;
  // Trap numbers and flag masks per source bit of src
  logic [6:0]  tnum [11] = '{7'h00, 7'h00, 7'h00, 7'h02, 7'h04, 7'h06,
                             7'h08, 7'h0a, 7'h0a, 7'h0a, 7'h0a};
  logic [15:0] tflg [11] = '{16'h0, 16'h0, 16'h0, 16'h8000, 16'h4000,
                             16'h2000, 16'h1000, 16'h0080, 16'h0008,
                             16'h0004, 16'h0002};

  itv_trap_vec i_itv_trap_vec (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
    .i_reg_rd(rd), .o_reg_rdata(rdata), .i_node_req(nreq),
    .i_hw_reset(src[0]), .i_sw_reset(src[1]), .i_wdt_ovf(src[2]),
    .i_nmi_pin(src[3]), .i_stk_over(src[4]), .i_stk_under(src[5]),
    .i_soft_break(src[6]), .i_undef_opc(src[7]), .i_prog_err(src[8]),
    .i_prot_fault(src[9]), .i_ill_word(src[10]), .i_swtrap_req(swreq),
    .i_swtrap_num(swnum), .i_cpu_prio(cpu_prio), .i_vec_ack(ack),
    .i_trap_ret(tret), .o_vec_valid(vld), .o_vec_addr(vaddr),
    .o_trap_num(num), .o_vec_prio(vprio), .o_vec_is_trap(itrap),
    .o_vec_is_swtrap(iswt), .o_trap_active(act));
  itv_core_model i_itv_core_model (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_vec_valid(vld), .i_vec_addr(vaddr), .i_trap_num(num),
    .i_vec_prio(vprio), .o_vec_ack(ack), .o_seen_addr(s_addr),
    .o_seen_num(s_num), .o_seen_prio(s_prio), .o_seen_cnt(s_cnt));

  // Clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [23:0] vec(input logic [7:0] s,
                                      input logic [1:0] c,
                                      input logic [6:0] n);
    return {s, 16'(n) << (SPC_BASE_SHIFT + c)};
  endfunction
  task automatic chk(input string what, input logic [23:0] e,
                     input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [15:0] e,
                      input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, 24'(e), 24'(rdata));
  endtask
  // Wait for the core to take one offer, then compare it
  task automatic expv(input logic [6:0] n, input logic [23:0] a);
    logic [15:0] c0;
    c0 = s_cnt;
    for (int i = 0; i < 60 && s_cnt == c0; i++) @(posedge clk);
    #1;
    chk("offer count", 24'(c0) + 24'h1, 24'(s_cnt));
    chk("trap number", 24'(n), 24'(s_num));
    chk("vector", a, s_addr);
  endtask
  task automatic idle10;
    logic [15:0] c0;
    c0 = s_cnt;
    repeat (10) @(posedge clk);
    chk("held offer", 24'(c0), 24'(s_cnt));
  endtask
  task automatic fire(input int k);
    @(posedge clk);
    src[k] <= 1'b1;
    repeat (k == 3 ? 3 : 1) @(posedge clk);
    src <= '0;
  endtask
  task automatic npulse(input logic [6:0] n);
    @(posedge clk);
    nreq[n - NODE_BASE] <= 1'b1;
    @(posedge clk);
    nreq <= '0;
  endtask
  task automatic endsvc;
    @(posedge clk);
    tret <= 1'b1;
    @(posedge clk);
    tret <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    summarize;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    expv(TRAP_RESET, 24'h000000);
    rreg(ADDR_VECTOR_SEGMENT_REG, 16'h0000, "segment");
    rreg(ADDR_CPU_CONFIG_REG_ONE, 16'h0000, "spacing");
    for (int k = 0; k < 11; k++) begin
      fire(k);
      expv(tnum[k], vec(8'h00, 2'h0, tnum[k]));
      rreg(ADDR_TRAPFLAG, tflg[k], "trap flags");
      wreg(ADDR_TRAPFLAG, tflg[k]);
      rreg(ADDR_TRAPFLAG, 16'h0000, "cleared flags");
      endsvc;
    end
    @(posedge clk);
    src <= 11'h090;
    @(posedge clk);
    src <= '0;
    expv(TRAP_STK_OVER, 24'h000010);
    endsvc;
    expv(TRAP_CLASS_B, 24'h000028);
    endsvc;
    fire(7);
    expv(TRAP_CLASS_B, 24'h000028);
    fire(5);
    expv(TRAP_STK_UNDER, 24'h000018);
    endsvc;
    wreg(ADDR_TRAPFLAG, 16'hffff);
    wreg(ADDR_NODESEL, 16'h005d);
    wreg(ADDR_NODECTRL, 16'h0043);
    wreg(ADDR_NODESEL, 16'h002a);
    wreg(ADDR_NODECTRL, 16'h0045);
    rreg(ADDR_NODECTRL, 16'h0045, "node control");
    npulse(TRAP_AS0_TX);
    expv(TRAP_AS0_TX, {8'h00, OFF_AS0_TX});
    chk("node prio", 24'h5, 24'(s_prio));
    npulse(TRAP_RTC);
    expv(TRAP_RTC, {8'h00, OFF_RTC});
    wreg(ADDR_VECTOR_SEGMENT_REG, 16'h0012);
    wreg(ADDR_CPU_CONFIG_REG_ONE, 16'h0001);
    npulse(TRAP_AS0_TX);
    expv(TRAP_AS0_TX, vec(8'h12, 2'h1, TRAP_AS0_TX));
    wreg(ADDR_VECTOR_SEGMENT_REG, 16'h0000);
    wreg(ADDR_CPU_CONFIG_REG_ONE, 16'h0000);
    wreg(ADDR_NODESEL, 16'h004b);
    wreg(ADDR_NODECTRL, 16'h00c7);
    expv(7'h4b, 24'h00012c);
    @(posedge clk);
    cpu_prio <= 4'h6;
    npulse(TRAP_AS0_TX);
    idle10;
    cpu_prio <= 4'h4;
    expv(TRAP_AS0_TX, {8'h00, OFF_AS0_TX});
    fire(4);
    expv(TRAP_STK_OVER, 24'h000010);
    chk("service active", 24'h1, 24'(act));
    chk("offer kind", 24'h2, 24'({itrap, iswt}));
    rreg(ADDR_STATUS, 16'h0002, "status");
    npulse(TRAP_AS0_TX);
    idle10;
    endsvc;
    expv(TRAP_AS0_TX, {8'h00, OFF_AS0_TX});
    @(posedge clk);
    swnum <= 7'h7f;
    swreq <= 1'b1;
    @(posedge clk);
    swreq <= 1'b0;
    expv(7'h7f, 24'h0001fc);
    chk("software prio", 24'h4, 24'(s_prio));
    chk("offer kind", 24'h1, 24'({itrap, iswt}));
    rreg(4'hf, 16'h0000, "unmapped read");
    summarize;
  end
endmodule
`default_nettype wire
